// >>> design/sgt_pkg.sv
/*
 * Shared definitions for the SPI command acceptance gate: opcodes, argument
 * byte counts, status byte layout, gate verdict and the executed-command record.
 * Assumes: every design file imports this package whole.
 */
package sgt_pkg;

	// Command opcodes seen on the SPI command port
	localparam logic [7:0] OP_PLAY_PROMPT = 8'ha6;
	localparam logic [7:0] OP_PLAY_PROMPT_IND = 8'hae;
	localparam logic [7:0] OP_PLAY_PROMPT_LOOP = 8'ha4;
	localparam logic [7:0] OP_PLAY_PROMPT_IND_LOOP = 8'hb2;
	localparam logic [7:0] OP_RUN_MACRO = 8'hb0;
	localparam logic [7:0] OP_RUN_MACRO_IND = 8'hbc;
	localparam logic [7:0] OP_PLAY_SILENCE = 8'ha8;
	localparam logic [7:0] OP_STOP = 8'h2a;
	localparam logic [7:0] OP_STOP_LOOP = 8'h2e;
	localparam logic [7:0] OP_PCM_READ = 8'hac;
	localparam logic [7:0] OP_AUDIO_SEND = 8'hc0;
	localparam logic [7:0] OP_READ_STATUS = 8'h40;
	localparam logic [7:0] OP_READ_INT = 8'h46;
	localparam logic [7:0] OP_IDENTITY_READ = 8'h48;
	localparam logic [7:0] OP_MEMORY_READ = 8'ha2;
	localparam logic [7:0] OP_MEMORY_WRITE = 8'ha0;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h24;
	localparam logic [7:0] OP_MASS_ERASE = 8'h26;
	localparam logic [7:0] OP_CHECKSUM = 8'hf2;
	localparam logic [7:0] OP_POWER_ON = 8'h10;
	localparam logic [7:0] OP_POWER_OFF = 8'h12;
	localparam logic [7:0] OP_SET_CLK_CFG = 8'h34;
	localparam logic [7:0] OP_RD_CLK_CFG = 8'hb6;
	localparam logic [7:0] OP_WR_CFG_REG = 8'hb8;
	localparam logic [7:0] OP_RD_CFG_REG = 8'hba;
	localparam logic [7:0] OP_RESET = 8'h14;

	// Argument bytes that must arrive before a command is resolved
	localparam logic [2:0] ARGS_NONE = 3'h0;
	localparam logic [2:0] ARGS_ONE = 3'h1;
	localparam logic [2:0] ARGS_TWO = 3'h2;
	localparam logic [2:0] ARGS_THREE = 3'h3;
	localparam logic [2:0] ARGS_FOUR = 3'h4;

	// Channel select value on which prompt and macro commands are ignored
	localparam logic [1:0] CHAN_NONE = 2'h3;
	localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
	localparam logic [2:0] BIT_COUNT_FIRST = 3'h0;

	// Device status byte, bit 7 down to bit 0
	typedef struct packed {
		logic poweredDownFlag;
		logic bufferReadyFlag;
		logic interruptFlag;
		logic unusedBit;
		logic [2:0] channelBusy;
		logic digitalBusyFlag;
	} sgt_status_t;

	// Verdict of the acceptance table for one opcode
	typedef struct packed {
		logic accept;
		logic ignore;
		logic tracksFinish;
		logic [2:0] argLen;
	} sgt_verdict_t;

	// Command handed to the core when accepted
	typedef struct packed {
		logic [7:0] opcode;
		logic [15:0] argWord;
	} sgt_cmd_t;

	// Main sequencer states, one-hot
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_OPCODE = 4'h2,
		S_ARGS = 4'h4,
		S_DRAIN = 4'h8
	} sgt_state_t;

endpackage

// >>> design/sgt_spi_shift.sv
/*
 * SPI byte shifter on the system clock: synchronises the pins, finds clock
 * edges, shifts command bytes in MSB first and the status byte out at once.
 * Assumes: mode 0 (clock idles low), link clock slow against sys_clk.
 */
module sgt_spi_shift
	import sgt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// SPI pins
	input wire logic sclkPin,
	input wire logic mosiPin,
	input wire logic selectN,
	output logic miso,
	output logic misoOe,
	// Byte side
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte,
	output logic byteDone,
	output logic frameEnd,
	output logic selected
);

	typedef struct packed {
		logic [2:0] sclkSync;
		logic [1:0] mosiSync;
		logic [2:0] selSync;
		logic [7:0] rxShift;
		logic [7:0] txShift;
		logic [2:0] bitCount;
		logic misoOut;
		logic done;
		logic ended;
	} sgt_shift_t;

	sgt_shift_t s_q, s_d;
	logic sclkRise, sclkFall, selFall, selRise;

	// Edge detection only looks at the second and third stages
	assign sclkRise = s_q.sclkSync[1] & ~s_q.sclkSync[2];
	assign sclkFall = ~s_q.sclkSync[1] & s_q.sclkSync[2];
	assign selFall = ~s_q.selSync[1] & s_q.selSync[2];
	assign selRise = s_q.selSync[1] & ~s_q.selSync[2];

	// Next state: sample on rising clock, shift out on falling clock
	always_comb begin
		s_d = s_q;
		s_d.sclkSync = {s_q.sclkSync[1:0], sclkPin};
		s_d.mosiSync = {s_q.mosiSync[0], mosiPin};
		s_d.selSync = {s_q.selSync[1:0], selectN};
		s_d.done = 1'b0;
		s_d.ended = selRise;
		if (selFall) begin
			s_d.bitCount = BIT_COUNT_FIRST;
			s_d.misoOut = txByte[7];
			s_d.txShift = {txByte[6:0], 1'b0};
		end else if (!s_q.selSync[1] && sclkRise) begin
			s_d.rxShift = {s_q.rxShift[6:0], s_q.mosiSync[1]};
			s_d.bitCount = s_q.bitCount + 3'h1;
			s_d.done = (s_q.bitCount == BIT_COUNT_LAST);
		end else if (!s_q.selSync[1] && sclkFall) begin
			if (s_q.bitCount == BIT_COUNT_FIRST) begin
				s_d.misoOut = txByte[7];
				s_d.txShift = {txByte[6:0], 1'b0};
			end else begin
				s_d.misoOut = s_q.txShift[7];
				s_d.txShift = {s_q.txShift[6:0], 1'b0};
			end
		end
	end

	// State register; select pin idles high
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.selSync <= 3'h7;
		end else begin
			s_q <= s_d;
		end
	end

	assign rxByte = s_q.rxShift;
	assign byteDone = s_q.done;
	assign frameEnd = s_q.ended;
	assign selected = ~s_q.selSync[2];
	assign miso = s_q.misoOut;
	assign misoOe = ~s_q.selSync[2];

endmodule

// >>> design/sgt_gate.sv
/*
 * Acceptance table: maps an opcode and the live status byte to a verdict.
 * Assumes: status comes from core logic on the same clock; purely combinational.
 */
module sgt_gate
	import sgt_pkg::*;
(
	// Decision inputs
	input wire logic [7:0] opcode,
	input wire sgt_status_t status,
	input wire logic [1:0] chanSel,
	// Verdict
	output sgt_verdict_t verdict
);

	logic ready, chanIdle, allIdle, chanCheck;

	// For plays and macros only the selected channel counts; the interrupt bit never does
	always_comb begin
		ready = !status.poweredDownFlag && status.bufferReadyFlag;
		chanIdle = (chanSel != CHAN_NONE) && !status.channelBusy[chanSel];
		allIdle = (status.channelBusy == 3'h0) && !status.digitalBusyFlag;
		chanCheck = 1'b0;
		verdict = '0;
		unique case (opcode)
			OP_PLAY_PROMPT: begin
				verdict.accept = ready && chanIdle && !status.digitalBusyFlag;
				verdict.argLen = ARGS_TWO;
				chanCheck = 1'b1;
			end
			OP_PLAY_PROMPT_IND, OP_PLAY_PROMPT_LOOP, OP_PLAY_PROMPT_IND_LOOP: begin
				verdict.accept = ready && chanIdle;
				verdict.argLen = (opcode == OP_PLAY_PROMPT_IND) ? ARGS_ONE :
					(opcode == OP_PLAY_PROMPT_LOOP) ? ARGS_FOUR : ARGS_THREE;
				chanCheck = 1'b1;
			end
			OP_PLAY_SILENCE: begin
				verdict.accept = ready && chanIdle;
				verdict.argLen = ARGS_ONE;
			end
			OP_RUN_MACRO, OP_RUN_MACRO_IND: begin
				verdict.accept = ready && chanIdle && !status.digitalBusyFlag;
				verdict.argLen = (opcode == OP_RUN_MACRO) ? ARGS_TWO : ARGS_ONE;
				chanCheck = 1'b1;
			end
			OP_STOP, OP_STOP_LOOP, OP_PCM_READ, OP_IDENTITY_READ, OP_POWER_OFF,
			OP_RD_CLK_CFG, OP_WR_CFG_REG, OP_RD_CFG_REG: begin
				verdict.accept = ready;
			end
			OP_AUDIO_SEND, OP_MEMORY_READ, OP_MEMORY_WRITE: begin
				verdict.accept = ready && allIdle;
			end
			OP_SECTOR_ERASE, OP_CHECKSUM: begin
				verdict.accept = ready && allIdle;
				verdict.argLen = ARGS_THREE;
			end
			OP_MASS_ERASE, OP_SET_CLK_CFG: begin
				verdict.accept = ready && allIdle;
				verdict.argLen = ARGS_ONE;
			end
			OP_READ_STATUS, OP_READ_INT, OP_RESET: begin
				verdict.accept = 1'b1;
			end
			OP_POWER_ON: begin
				verdict.accept = status.poweredDownFlag && !status.bufferReadyFlag;
			end
			default: begin
				verdict.accept = 1'b0;
			end
		endcase
		verdict.ignore = chanCheck && (chanSel == CHAN_NONE);
		verdict.tracksFinish = chanCheck || (opcode == OP_PLAY_SILENCE);
	end

endmodule

// >>> design/sgt_command_gate.sv
/*
 * SPI command acceptance gate: receives command frames, judges each opcode
 * against the status byte, hands accepted commands to the core, raises the
 * error and finished flags and drives the interrupt pin.
 * Assumes: status inputs and playDone come from core logic on sys_clk; the
 * SPI pins come from an outside master and are synchronised here.
 */
// Functional notes
// - Execute only when status allows, else error
// - Status byte: down, ready, int, spare, busy bits
// - Prompt and silence plays: ready, channel idle
// - Only the selected channel busy flag counts
// - Macros also need digital busy clear
// - Stop, reads, config, power-off: just ready; the code makes set clock config also need everything idle
// - Data, erase, checksum need everything idle
// - Status, interrupt query, reset always accepted
// - Power-on needs powered down, not ready
// - Status byte returned during every byte
// - Plain prompt also needs digital busy clear
// - Aborted after opcode: no interrupt at all
// - Finished playback raises finished flag
// - Prompt commands ignored on channel select three
// - Status shifted out while opcode shifts in
// - Interrupt query clears error and finished flags
module sgt_command_gate
	import sgt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// SPI pins
	input wire logic sclkPin,
	input wire logic mosiPin,
	input wire logic selectN,
	output logic miso,
	output logic misoOe,
	// Core status
	input wire logic poweredDownFlag,
	input wire logic bufferReadyFlag,
	input wire logic channel2BusyFlag,
	input wire logic channel1BusyFlag,
	input wire logic channel0BusyFlag,
	input wire logic digitalBusyFlag,
	input wire logic [1:0] spiChannelSelectField,
	input wire logic playDone,
	// Command hand-off
	output logic cmdExec,
	output sgt_cmd_t cmdOut,
	output logic resetCmd,
	// Interrupt state
	output logic commandErrorFlag,
	output logic commandFinishedInterrupt,
	output logic intN,
	output sgt_status_t deviceStatusByte
);

	typedef struct packed {
		sgt_state_t st;
		logic [7:0] opcode;
		logic [2:0] argLeft;
		logic [15:0] argWord;
		logic accept;
		logic ignore;
		logic tracksFinish;
		logic errFlag;
		logic finFlag;
		logic playActive;
		logic execPulse;
		logic resetPulse;
		sgt_cmd_t cmd;
	} sgt_main_t;

	sgt_main_t m_q, m_d;
	sgt_status_t status;
	sgt_verdict_t verdict;
	logic [7:0] rxByte;
	logic byteDone, frameEnd, selected;
	logic resolve;
	logic [15:0] nextWord;

	// Live status byte, shifted out during every command byte
	always_comb begin
		status.poweredDownFlag = poweredDownFlag;
		status.bufferReadyFlag = bufferReadyFlag;
		status.interruptFlag = m_q.errFlag | m_q.finFlag;
		status.unusedBit = 1'b0;
		status.channelBusy = {channel2BusyFlag, channel1BusyFlag, channel0BusyFlag};
		status.digitalBusyFlag = digitalBusyFlag;
	end

	// Pin side: synchronisers, bit shifting, status out
	sgt_spi_shift u_shift (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.sclkPin(sclkPin),
		.mosiPin(mosiPin),
		.selectN(selectN),
		.miso(miso),
		.misoOe(misoOe),
		.txByte(status),
		.rxByte(rxByte),
		.byteDone(byteDone),
		.frameEnd(frameEnd),
		.selected(selected)
	);

	// Acceptance table on the freshly received opcode
	sgt_gate u_gate (
		.opcode(rxByte),
		.status(status),
		.chanSel(spiChannelSelectField),
		.verdict(verdict)
	);

	// A command resolves on its last counted byte
	assign resolve = byteDone && (
		(m_q.st == S_OPCODE && verdict.argLen == ARGS_NONE) ||
		(m_q.st == S_ARGS && m_q.argLeft == ARGS_ONE));
	assign nextWord = {m_q.argWord[7:0], rxByte};

	// Sequencer and flag logic
	always_comb begin
		m_d = m_q;
		m_d.execPulse = 1'b0;
		m_d.resetPulse = 1'b0;
		unique case (m_q.st)
			S_IDLE: begin
				if (selected) begin
					m_d.st = S_OPCODE;
				end
			end
			S_OPCODE: begin
				if (frameEnd) begin
					m_d.st = S_IDLE;
				end else if (byteDone) begin
					m_d.opcode = rxByte;
					m_d.argWord = '0;
					m_d.accept = verdict.accept;
					m_d.ignore = verdict.ignore;
					m_d.tracksFinish = verdict.tracksFinish;
					m_d.argLeft = verdict.argLen;
					m_d.st = (verdict.argLen == ARGS_NONE) ? S_DRAIN : S_ARGS;
				end
			end
			S_ARGS: begin
				if (frameEnd) begin
					m_d.st = S_IDLE;
				end else if (byteDone) begin
					m_d.argWord = nextWord;
					m_d.argLeft = m_q.argLeft - ARGS_ONE;
					if (m_q.argLeft == ARGS_ONE) begin
						m_d.st = S_DRAIN;
					end
				end
			end
			S_DRAIN: begin
				if (frameEnd) begin
					m_d.st = S_IDLE;
				end
			end
			default: begin
				m_d.st = S_IDLE;
			end
		endcase
		// Interrupt query clears, later sets win over it
		if (resolve && m_q.st == S_OPCODE && rxByte == OP_READ_INT) begin
			m_d.errFlag = 1'b0;
			m_d.finFlag = 1'b0;
		end
		// Completion of an accepted playback
		if (playDone && m_q.playActive) begin
			m_d.finFlag = 1'b1;
			m_d.playActive = 1'b0;
		end
		// Verdict carried out on the last counted byte
		if (resolve) begin
			if (m_q.st == S_OPCODE) begin
				m_d.accept = verdict.accept;
				m_d.ignore = verdict.ignore;
			end
			if ((m_q.st == S_OPCODE) ? verdict.ignore : m_q.ignore) begin
				m_d.accept = 1'b0;
			end else if ((m_q.st == S_OPCODE) ? verdict.accept : m_q.accept) begin
				m_d.execPulse = 1'b1;
				m_d.cmd.opcode = (m_q.st == S_OPCODE) ? rxByte : m_q.opcode;
				m_d.cmd.argWord = (m_q.st == S_OPCODE) ? 16'h0000 : nextWord;
				m_d.resetPulse = (m_q.st == S_OPCODE) && (rxByte == OP_RESET);
				if (m_q.st == S_ARGS && m_q.tracksFinish) begin
					m_d.playActive = 1'b1;
				end
			end else begin
				m_d.errFlag = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			m_q <= '0;
			m_q.st <= S_IDLE;
		end else begin
			m_q <= m_d;
		end
	end

	assign cmdExec = m_q.execPulse;
	assign cmdOut = m_q.cmd;
	assign resetCmd = m_q.resetPulse;
	assign commandErrorFlag = m_q.errFlag;
	assign commandFinishedInterrupt = m_q.finFlag;
	assign intN = ~(m_q.errFlag | m_q.finFlag);
	assign deviceStatusByte = status;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Rejected command raises the error flag and is not executed
	reject_sets_error_a: assert property (
		resolve && !(m_q.st == S_OPCODE ? verdict.ignore : m_q.ignore) &&
		!(m_q.st == S_OPCODE ? verdict.accept : m_q.accept)
		|=> m_q.errFlag && !m_q.execPulse)
		else $error("rejected command did not raise error");

	// Accepted command executes for exactly one cycle
	accept_exec_once_a: assert property (
		resolve && !(m_q.st == S_OPCODE ? verdict.ignore : m_q.ignore) &&
		(m_q.st == S_OPCODE ? verdict.accept : m_q.accept)
		|=> m_q.execPulse ##1 !m_q.execPulse)
		else $error("accepted command not executed once");

	// Abort after opcode leaves flags and hand-off untouched
	abort_silent_a: assert property (
		m_q.st == S_ARGS && frameEnd && !playDone
		|=> $stable(m_q.errFlag) && $stable(m_q.finFlag) && !m_q.execPulse)
		else $error("aborted command raised an interrupt");

	// Channel select three drops prompt commands silently
	chan3_ignored_a: assert property (
		resolve && m_q.st == S_ARGS && m_q.ignore
		|=> !m_q.execPulse && m_q.errFlag == $past(m_q.errFlag))
		else $error("prompt command acted on with channel three");

	// Playback completion sets the finished flag
	finish_flag_a: assert property (
		m_q.playActive && playDone |=> m_q.finFlag && !m_q.playActive)
		else $error("playback completion not flagged");

	// Interrupt query clears flags when nothing new arrives
	int_query_clear_a: assert property (
		resolve && m_q.st == S_OPCODE && rxByte == OP_READ_INT && !playDone
		|=> !m_q.errFlag && !m_q.finFlag && intN)
		else $error("interrupt query left flags set");

	// Accepted plain prompt executes and hands over its two argument bytes
	prompt_gate_a: assert property (
		resolve && m_q.st == S_ARGS && m_q.opcode == OP_PLAY_PROMPT
		&& m_q.accept && !m_q.ignore |=> m_q.execPulse && m_q.cmd.argWord == $past(nextWord))
		else $error("prompt index not handed over");

	// Power-on accepted only when powered down and not ready
	power_on_gate_a: assert property (
		byteDone && m_q.st == S_OPCODE && rxByte == OP_POWER_ON && verdict.accept
		|-> poweredDownFlag && !bufferReadyFlag)
		else $error("power-on accepted in wrong state");

	// Status byte layout with spare bit zero and interrupt bit live
	status_layout_a: assert property (
		deviceStatusByte[4] == 1'b0 && deviceStatusByte[5] == !intN
		&& deviceStatusByte[7] == poweredDownFlag)
		else $error("status byte layout wrong");

	// Status read and reset always accepted
	always_accept_a: assert property (
		byteDone && m_q.st == S_OPCODE && (rxByte == OP_READ_STATUS || rxByte == OP_RESET)
		|=> m_q.execPulse)
		else $error("unconditional command refused");

	// Plain prompt refused while the digital side is busy
	prompt_digital_a: assert property (
		byteDone && m_q.st == S_OPCODE && rxByte == OP_PLAY_PROMPT && digitalBusyFlag
		|=> !m_q.accept)
		else $error("plain prompt accepted with digital busy");

	// Macros refused while the digital side is busy
	macro_digital_a: assert property (
		byteDone && m_q.st == S_OPCODE && digitalBusyFlag
		&& (rxByte == OP_RUN_MACRO || rxByte == OP_RUN_MACRO_IND) |=> !m_q.accept)
		else $error("macro accepted with digital busy");

	// Stop runs whenever powered up and ready, busy or not
	stop_ready_a: assert property (
		byteDone && m_q.st == S_OPCODE && rxByte == OP_STOP
		&& !poweredDownFlag && bufferReadyFlag |=> m_q.execPulse)
		else $error("stop refused while ready");

	// Audio send refused while any channel or the digital side is busy
	audio_idle_a: assert property (
		byteDone && m_q.st == S_OPCODE && rxByte == OP_AUDIO_SEND
		&& (channel2BusyFlag || channel1BusyFlag || channel0BusyFlag || digitalBusyFlag)
		|=> !m_q.execPulse && m_q.errFlag)
		else $error("audio send accepted while busy");

	// Reset request only travels with its own hand-off
	reset_with_exec_a: assert property (
		resetCmd |-> cmdExec && cmdOut.opcode == OP_RESET)
		else $error("reset pulse without reset command");

endmodule

// >>> tb/sgt_host_model.sv
/*
 * Host controller model: sends mode 0 frames MSB first, captures the status byte.
 * Assumes: sys_clk from the bench; link half period is four sys_clk cycles.
 */
module sgt_host_model
	import sgt_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// SPI pins
	output logic sclkPin,
	output logic mosiPin,
	output logic selectN,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] rxQ [5];

	// Link idles low, deselected
	initial begin
		sclkPin = 1'b0;
		mosiPin = 1'b1;
		selectN = 1'b1;
	end

	// Waits a number of system clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One frame of n bytes; miso is taken just before each rise
	task automatic frame(input logic [7:0] tx [5], input int n);
		selectN <= 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				mosiPin <= tx[i][b];
				tick(4);
				rxQ[i][b] = miso;
				sclkPin <= 1'b1;
				tick(4);
				sclkPin <= 1'b0;
			end
		end
		tick(4);
		selectN <= 1'b1;
		mosiPin <= ~mosiPin; // Released line shows no stale bit
	endtask
endmodule

// >>> tb/test_sgt_command_gate.sv
/*
 * Self-checking bench for the command acceptance gate: directed corners and
 * random commands against random status.
 * Assumes: sgt_host_model plays the SPI master; bench drives core status.
 */
module test_sgt_command_gate
	import sgt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk, arst_n, playDone, sclkPin, mosiPin, selectN, miso, misoOe, misoLine, misoHold;
	logic cmdExec, resetCmd, commandErrorFlag, commandFinishedInterrupt, intN;
	logic [1:0] chSel;
	logic expErr, expFin, rstSeen;
	logic [23:0] lastCmd;
	sgt_status_t stIn, devStat, s;
	sgt_cmd_t cmdOut;
	int seed = 32'h7c8d;
	int err_count, total_checks, execSeen;
	logic [7:0] ops [27] = '{8'ha6, 8'hae, 8'ha4, 8'hb2, 8'hb0, 8'hbc, 8'ha8, 8'h2a, 8'h2e,
		8'hac, 8'hc0, 8'h40, 8'h46, 8'h48, 8'ha2, 8'ha0, 8'h24, 8'h26, 8'hf2, 8'h10,
		8'h12, 8'h34, 8'hb6, 8'hb8, 8'hba, 8'h14, 8'h55};

	sgt_command_gate dut (.sys_clk(sys_clk), .arst_n(arst_n), .sclkPin(sclkPin),
		.mosiPin(mosiPin), .selectN(selectN), .miso(miso), .misoOe(misoOe),
		.poweredDownFlag(stIn.poweredDownFlag), .bufferReadyFlag(stIn.bufferReadyFlag),
		.channel2BusyFlag(stIn.channelBusy[2]), .channel1BusyFlag(stIn.channelBusy[1]),
		.channel0BusyFlag(stIn.channelBusy[0]), .digitalBusyFlag(stIn.digitalBusyFlag),
		.spiChannelSelectField(chSel), .playDone(playDone), .cmdExec(cmdExec),
		.cmdOut(cmdOut), .resetCmd(resetCmd), .commandErrorFlag(commandErrorFlag),
		.commandFinishedInterrupt(commandFinishedInterrupt), .intN(intN),
		.deviceStatusByte(devStat));
	sgt_host_model host (.sys_clk(sys_clk), .sclkPin(sclkPin), .mosiPin(mosiPin),
		.selectN(selectN), .miso(misoLine));

	// Undriven miso shows the inverse of its last driven level
	assign misoLine = misoOe ? miso : ~misoHold;
	always @(posedge sys_clk) if (misoOe === 1'b1) misoHold <= miso;

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Counts handed-off commands, sampled away from the active edge
	always @(negedge sys_clk) if (cmdExec === 1'b1) begin
		execSeen++;
		lastCmd = cmdOut;
		rstSeen = resetCmd;
	end

	// Compares and counts
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Expected outcome: 0 rejected, 1 accepted, 2 ignored
	function automatic logic [1:0] verdict(input logic [7:0] op, input sgt_status_t st,
		input logic [1:0] ch);
		logic base, idle, all;
		base = !st.poweredDownFlag && st.bufferReadyFlag;
		idle = (ch != 2'h3) && !st.channelBusy[ch];
		all = (st.channelBusy == 3'h0) && !st.digitalBusyFlag;
		case (op)
			8'h40, 8'h46, 8'h14: return 2'h1;
			8'h10: return {1'b0, st.poweredDownFlag && !st.bufferReadyFlag};
			8'ha6, 8'hb0, 8'hbc: return (ch == 2'h3) ? 2'h2 : {1'b0, base && idle && !st.digitalBusyFlag};
			8'hae, 8'ha4, 8'hb2: return (ch == 2'h3) ? 2'h2 : {1'b0, base && idle};
			8'ha8: return {1'b0, base && idle};
			8'h2a, 8'h2e, 8'hac, 8'h48, 8'h12, 8'hb6, 8'hb8, 8'hba: return {1'b0, base};
			8'hc0, 8'ha2, 8'ha0, 8'h24, 8'h26, 8'hf2, 8'h34: return {1'b0, base && all};
			default: return 2'h0;
		endcase
	endfunction

	// Argument bytes that follow each opcode
	function automatic int nargs(input logic [7:0] op);
		case (op)
			8'ha4: return 4;
			8'hb2, 8'h24, 8'hf2: return 3;
			8'ha6, 8'hb0: return 2;
			8'hae, 8'hbc, 8'ha8, 8'h26, 8'h34: return 1;
			default: return 0;
		endcase
	endfunction

	// Sends one frame of n bytes under status st and checks status, hand-off and flags; the argument only for 0 or 2 argument bytes
	task automatic run(input logic [7:0] op, input int n, input logic [1:0] ch, input sgt_status_t st);
		logic [7:0] tx [5];
		logic [1:0] v;
		logic full;
		int na, e0;
		sgt_status_t sx;
		na = nargs(op);
		tx[0] = op;
		for (int i = 1; i < 5; i++) tx[i] = 8'($random(seed));
		v = verdict(op, st, ch);
		full = (n == na + 1);
		e0 = execSeen;
		stIn <= st;
		chSel <= ch;
		@(posedge sys_clk);
		sx = st;
		sx.unusedBit = 1'b0;
		sx.interruptFlag = expErr | expFin;
		check("status port", devStat, sx);
		host.frame(tx, n);
		repeat (12) @(posedge sys_clk);
		for (int i = 0; i < n; i++) check("status byte", host.rxQ[i], sx);
		check("exec count", execSeen - e0, full && v == 2'h1);
		if (full && v == 2'h1) begin
			check("opcode", lastCmd[23:16], op);
			if (na == 0 || na == 2) check("argument", lastCmd[15:0], na == 0 ? 16'h0 : {tx[1], tx[2]});
			check("reset pulse", rstSeen, op == 8'h14);
			if (op == 8'h46) begin
				expErr = 1'b0;
				expFin = 1'b0;
			end
		end
		if (full && v == 2'h0) expErr = 1'b1;
		check("error flag", commandErrorFlag, expErr);
		check("finished flag", commandFinishedInterrupt, expFin);
		check("interrupt pin", intN, !(expErr | expFin));
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		arst_n = 1'b0;
		stIn = '0;
		chSel = 2'h0;
		playDone = 1'b0;
		expErr = 1'b0;
		expFin = 1'b0;
		misoHold = 1'b0;
		repeat (3) @(posedge sys_clk);
		check("oe at reset", misoOe, 1'b0);
		check("int at reset", intN, 1'b1);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		// Prompt on channel 1 with the other two busy, then completion
		s = 8'h4a;
		run(8'ha6, 3, 2'h1, s);
		playDone <= 1'b1;
		@(posedge sys_clk);
		playDone <= 1'b0;
		repeat (3) @(posedge sys_clk);
		expFin = 1'b1;
		check("finished flag", commandFinishedInterrupt, expFin);
		check("interrupt pin", intN, 1'b0);
		run(8'h46, 1, 2'h0, s);
		$display("test prompt done");
		// Digital busy rejects, aborts stay silent, select three ignores prompt and rejects silence
		s = 8'h41;
		run(8'ha6, 3, 2'h0, s);
		run(8'h46, 1, 2'h0, s);
		run(8'ha6, 1, 2'h0, s);
		run(8'ha6, 2, 2'h0, s);
		run(8'ha6, 3, 2'h3, s);
		run(8'ha8, 2, 2'h3, 8'h40);
		$display("test corners done");
		// Random commands under random status
		for (int k = 0; k < 120; k++) begin
			logic [7:0] op;
			s = 8'($random(seed));
			if (k % 4 != 0) begin
				s.poweredDownFlag = 1'b0;
				s.bufferReadyFlag = 1'b1;
			end
			if (k % 3 == 0) begin
				s.channelBusy = 3'h0;
				s.digitalBusyFlag = 1'b0;
			end
			op = (k < 27) ? ops[k] : ops[$unsigned($random(seed)) % 27];
			run(op, nargs(op) + 1, 2'($random(seed)), s);
			if (expErr && k % 5 == 0) run(8'h46, 1, 2'h0, s);
		end
		$display("test random done");
		report_and_stop();
	end
endmodule
